/* rtl/ftr_top.sv */
// FIFO threshold detection and serial readout
// What this block does
// - 24-bit limit register at 0x3C, reset value 0xFFF000.
// - Upper limit in bits 23:12, reset 0xFFF; result at or above sets high flag.
// - Lower limit in bits 11:0, reset 0; result at or below sets low flag.
// - Compare only samples whose channel has its compare enable set.
// - Serial read of 0x3D returns 16-bit FIFO data; register is read-only.
// - Read data register shows 0x0000 before any sample is stored.
// - High and low flags clear when the FIFO is emptied, unless a result sets them in that same cycle.
// - Each flag's interrupt follows that flag exactly.
// - Empty flag sets when FIFO goes empty, including last read; resets to 1.
`default_nettype none
module ftr_top
	import ftr_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_resetn,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_mosi,
	output logic o_miso,
	output logic o_miso_oe,
	input wire logic i_sample_valid,
	input wire logic [DATA_W-1:0] i_sample_data,
	input wire logic [CH_W-1:0] i_sample_channel,
	input wire logic [NUM_CH-1:0] i_channel_compare_enable,
	output logic o_sample_ready,
	output logic o_above_limit_flag,
	output logic o_below_limit_flag,
	output logic o_empty_flag,
	output logic o_above_limit_irq,
	output logic o_below_limit_irq,
	output logic o_empty_irq
);
	// Reset release
	logic rst_q1, rst_n;
	always_ff @(posedge i_mclk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	// Pin synchronisers: sclk, cs_n, mosi
	logic [SYNC_N-1:0] pin_raw, pin_q1, pin_q2;
	assign pin_raw = {i_sclk, i_cs_n, i_mosi};
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
			always_ff @(posedge i_mclk or negedge rst_n) begin
				if (!rst_n) begin
					pin_q1[gi] <= 1'b1;
					pin_q2[gi] <= 1'b1;
				end else begin
					pin_q1[gi] <= pin_raw[gi];
					pin_q2[gi] <= pin_q1[gi];
				end
			end
		end
	endgenerate

	logic sclk_s, cs_n_s, mosi_s, sclk_prev, sclk_rise, sclk_fall;
	assign sclk_s = pin_q2[2];
	assign cs_n_s = pin_q2[1];
	assign mosi_s = pin_q2[0];
	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			sclk_prev <= 1'b1;
		end else begin
			sclk_prev <= sclk_s;
		end
	end
	assign sclk_rise = sclk_s && !sclk_prev;
	assign sclk_fall = !sclk_s && sclk_prev;

	// Sample path through the FIFO
	ftr_stream_if #(.W(DATA_W)) in_s ();
	ftr_stream_if #(.W(DATA_W)) out_s ();
	logic pop_pulse;
	assign in_s.valid = i_sample_valid;
	assign in_s.data = i_sample_data;
	assign out_s.ready = pop_pulse;
	assign o_sample_ready = in_s.ready;

	ftr_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_mclk(i_mclk),
		.i_rst_n(rst_n),
		.in_s(in_s),
		.out_s(out_s)
	);

	// Serial register access
	ftr_spi_e state, next_state;
	logic [4:0] bit_cnt, next_bit_cnt, data_last, next_data_last;
	logic [LIMIT_W-1:0] in_shift, next_in_shift, out_shift, next_out_shift;
	logic [LIMIT_W-1:0] limit_pair, next_limit_pair;
	logic [DATA_W-1:0] fifo_read_port, next_fifo_read_port;
	logic [7:0] cmd, next_cmd, cmd_word;
	logic next_miso, next_miso_oe, next_pop_pulse;
	logic cmd_done, data_done;

	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_data_last = data_last;
		next_in_shift = in_shift;
		next_out_shift = out_shift;
		next_limit_pair = limit_pair;
		next_fifo_read_port = fifo_read_port;
		next_cmd = cmd;
		next_miso = o_miso;
		next_miso_oe = o_miso_oe;
		next_pop_pulse = 1'b0;
		cmd_word = {in_shift[6:0], mosi_s};
		cmd_done = 1'b0;
		data_done = 1'b0;
		if (cs_n_s) begin
			next_state = FTR_IDLE;
			next_miso_oe = 1'b0;
		end else begin
			case (state)
				FTR_IDLE: begin
					next_state = FTR_CMD;
					next_bit_cnt = '0;
				end
				FTR_CMD: begin
					if (sclk_rise) begin
						next_in_shift = {in_shift[LIMIT_W-2:0], mosi_s};
						next_bit_cnt = bit_cnt + 5'h01;
						if (bit_cnt == CMD_LAST) begin
							cmd_done = 1'b1;
							next_cmd = cmd_word;
							next_bit_cnt = '0;
							next_data_last = ftr_data_last(cmd_word[ADDR_MSB:0]);
							next_state = FTR_DATA;
							next_out_shift = '0;
							if (cmd_word[CMD_RW_BIT] && cmd_word[ADDR_MSB:0] == ADDR_LIMIT) begin
								next_out_shift = limit_pair;
							end else if (cmd_word[CMD_RW_BIT] && cmd_word[ADDR_MSB:0] == ADDR_READ) begin
								// Head of FIFO, or last value when empty
								if (out_s.valid) begin
									next_fifo_read_port = out_s.data;
								end
								next_out_shift = {(out_s.valid ? out_s.data : fifo_read_port), PAD_BYTE};
							end
						end
					end
				end
				FTR_DATA: begin
					if (sclk_fall) begin
						next_miso = out_shift[LIMIT_W-1];
						next_out_shift = {out_shift[LIMIT_W-2:0], 1'b0};
						next_miso_oe = cmd[CMD_RW_BIT];
					end
					if (sclk_rise) begin
						next_in_shift = {in_shift[LIMIT_W-2:0], mosi_s};
						next_bit_cnt = bit_cnt + 5'h01;
						if (bit_cnt == data_last) begin
							data_done = 1'b1;
							next_state = FTR_DONE;
							if (!cmd[CMD_RW_BIT] && cmd[ADDR_MSB:0] == ADDR_LIMIT) begin
								next_limit_pair = {in_shift[LIMIT_W-2:0], mosi_s};
							end
							if (cmd[CMD_RW_BIT] && cmd[ADDR_MSB:0] == ADDR_READ) begin
								next_pop_pulse = out_s.valid;
							end
						end
					end
				end
				FTR_DONE: begin
					if (sclk_fall) begin
						next_miso_oe = 1'b0;
					end
				end
				default: next_state = FTR_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			state <= FTR_IDLE;
			bit_cnt <= '0;
			data_last <= OTHER_LAST;
			in_shift <= '0;
			out_shift <= '0;
			limit_pair <= LIMIT_RESET;
			fifo_read_port <= DATA_RESET;
			cmd <= '0;
			o_miso <= 1'b0;
			o_miso_oe <= 1'b0;
			pop_pulse <= 1'b0;
		end else begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			data_last <= next_data_last;
			in_shift <= next_in_shift;
			out_shift <= next_out_shift;
			limit_pair <= next_limit_pair;
			fifo_read_port <= next_fifo_read_port;
			cmd <= next_cmd;
			o_miso <= next_miso;
			o_miso_oe <= next_miso_oe;
			pop_pulse <= next_pop_pulse;
		end
	end

	// Threshold detection and status flags
	logic push, cmp_en, hit_above, hit_below, was_valid, emptied;
	logic next_above, next_below, next_empty;
	logic [HALF_W-1:0] sample_cmp;

	always_comb begin
		push = i_sample_valid && in_s.ready;
		cmp_en = i_channel_compare_enable[i_sample_channel];
		sample_cmp = i_sample_data[DATA_W-1:CMP_LSB];
		hit_above = push && cmp_en && sample_cmp >= limit_pair[UPPER_MSB:UPPER_LSB];
		hit_below = push && cmp_en && sample_cmp <= limit_pair[LOWER_MSB:LOWER_LSB];
		emptied = was_valid && !out_s.valid;
		// Set wins over the empty clear
		next_above = (o_above_limit_flag && !emptied) || hit_above;
		next_below = (o_below_limit_flag && !emptied) || hit_below;
		next_empty = !out_s.valid;
	end

	always_ff @(posedge i_mclk or negedge rst_n) begin
		if (!rst_n) begin
			was_valid <= 1'b0;
			o_above_limit_flag <= 1'b0;
			o_below_limit_flag <= 1'b0;
			o_empty_flag <= 1'b1;
			o_above_limit_irq <= 1'b0;
			o_below_limit_irq <= 1'b0;
			o_empty_irq <= 1'b1;
		end else begin
			was_valid <= out_s.valid;
			o_above_limit_flag <= next_above;
			o_below_limit_flag <= next_below;
			o_empty_flag <= next_empty;
			o_above_limit_irq <= next_above;
			o_below_limit_irq <= next_below;
			o_empty_irq <= next_empty;
		end
	end

	// Checks
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!rst_n);

	property p_limit_write;
		$changed(limit_pair) |-> $past(data_done && !cmd[CMD_RW_BIT] && cmd[ADDR_MSB:0] == ADDR_LIMIT);
	endproperty
	a_limit_write: assert property (p_limit_write) else $error("limit changed without a write");

	property p_above;
		hit_above |=> o_above_limit_flag ##0 o_above_limit_irq;
	endproperty
	a_above: assert property (p_above) else $error("high flag not set");

	property p_below;
		hit_below |=> o_below_limit_flag;
	endproperty
	a_below: assert property (p_below) else $error("low flag not set");

	property p_enable_gate;
		$rose(o_above_limit_flag) || $rose(o_below_limit_flag) |->
			$past(push && i_channel_compare_enable[i_sample_channel]);
	endproperty
	a_enable_gate: assert property (p_enable_gate) else $error("flag from disabled channel");

	property p_read_pop;
		data_done && cmd[CMD_RW_BIT] && cmd[ADDR_MSB:0] == ADDR_READ && out_s.valid |=> pop_pulse ##1 !pop_pulse;
	endproperty
	a_read_pop: assert property (p_read_pop) else $error("read did not pop once");

	property p_port_hold;
		$changed(fifo_read_port) |-> $past(cmd_done && out_s.valid);
	endproperty
	a_port_hold: assert property (p_port_hold) else $error("read port changed unexpectedly");

	property p_clear;
		emptied && !push |=> !o_above_limit_flag && !o_below_limit_flag;
	endproperty
	a_clear: assert property (p_clear) else $error("flags not cleared on empty");

	property p_lockstep;
		o_above_limit_irq == o_above_limit_flag && o_below_limit_irq == o_below_limit_flag &&
			o_empty_irq == o_empty_flag;
	endproperty
	a_lockstep: assert property (p_lockstep) else $error("interrupt differs from flag");

	property p_empty;
		pop_pulse && !push ##1 !out_s.valid |=> o_empty_flag;
	endproperty
	a_empty: assert property (p_empty) else $error("empty flag not set");

	property p_miso_quiet;
		o_miso_oe |-> cmd[CMD_RW_BIT] && $past(!cs_n_s);
	endproperty
	a_miso_quiet: assert property (p_miso_quiet) else $error("miso driven outside read");

	c_limit_write: cover property (data_done && !cmd[CMD_RW_BIT] && cmd[ADDR_MSB:0] == ADDR_LIMIT);
	c_read_pop: cover property (pop_pulse ##[1:4] emptied);
	c_above: cover property (hit_above);
	c_full: cover property (!in_s.ready);
endmodule : ftr_top
`default_nettype wire

/* rtl/ftr_pkg.sv */
// Constants, types and decode helpers for the FIFO threshold and readout block
`default_nettype none
package ftr_pkg;
	localparam int DATA_W = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int LIMIT_W = 24;
	localparam int HALF_W = 12;
	localparam int CH_W = 4;
	localparam int NUM_CH = 16;
	localparam int SYNC_N = 3;
	localparam int UPPER_MSB = 23;
	localparam int UPPER_LSB = 12;
	localparam int LOWER_MSB = 11;
	localparam int LOWER_LSB = 0;
	localparam int CMP_LSB = DATA_W - HALF_W;
	localparam int CMD_RW_BIT = 7;
	localparam int ADDR_MSB = 5;
	localparam logic [5:0] ADDR_LIMIT = 6'h3C;
	localparam logic [5:0] ADDR_READ = 6'h3D;
	localparam logic [LIMIT_W-1:0] LIMIT_RESET = 24'hFFF000;
	localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
	localparam logic [4:0] CMD_LAST = 5'h07;
	localparam logic [4:0] LIMIT_LAST = 5'h17;
	localparam logic [4:0] READ_LAST = 5'h0F;
	localparam logic [4:0] OTHER_LAST = 5'h07;
	localparam logic [7:0] PAD_BYTE = 8'h00;

	typedef enum logic [1:0] {FTR_IDLE, FTR_CMD, FTR_DATA, FTR_DONE} ftr_spi_e;

	// Index of the last data bit for a register address
	function automatic logic [4:0] ftr_data_last(input logic [5:0] addr);
		case (addr)
			ADDR_LIMIT: ftr_data_last = LIMIT_LAST;
			ADDR_READ: ftr_data_last = READ_LAST;
			default: ftr_data_last = OTHER_LAST;
		endcase
	endfunction : ftr_data_last
endpackage : ftr_pkg
`default_nettype wire

/* rtl/ftr_stream_if.sv */
// Valid/ready stream carrier between the block's own modules
`default_nettype none
interface ftr_stream_if #(parameter int W = 16) ();
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface : ftr_stream_if
`default_nettype wire

/* rtl/ftr_mem.sv */
// Sample storage with registered, write-through read port
`default_nettype none
module ftr_mem #(
	parameter int W = 16,
	parameter int DEPTH = 8,
	parameter int AW = $clog2(DEPTH)
) (
	input wire logic i_mclk,
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [W-1:0] i_wdata,
	input wire logic [AW-1:0] i_raddr,
	output logic [W-1:0] o_rdata
);
	logic [W-1:0] store [DEPTH];

	always_ff @(posedge i_mclk) begin
		if (i_we) begin
			store[i_waddr] <= i_wdata;
		end
		// Bypass keeps a freshly written head visible
		if (i_we && i_waddr == i_raddr) begin
			o_rdata <= i_wdata;
		end else begin
			o_rdata <= store[i_raddr];
		end
	end
endmodule : ftr_mem
`default_nettype wire

/* rtl/ftr_fifo.sv */
// Show-ahead sample FIFO with registered ready
`default_nettype none
module ftr_fifo #(
	parameter int W = 16,
	parameter int DEPTH = 8
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	ftr_stream_if.snk in_s,
	ftr_stream_if.src out_s
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_COUNT = (AW + 1)'(DEPTH);
	localparam logic [AW:0] ONE_COUNT = (AW + 1)'(1);
	localparam logic [AW-1:0] ONE_PTR = AW'(1);

	logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [AW:0] count, next_count;
	logic ready, next_ready;
	logic push, pop;

	always_comb begin
		push = in_s.valid && ready;
		pop = out_s.ready && (count != '0);
		next_wr_ptr = push ? wr_ptr + ONE_PTR : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + ONE_PTR : rd_ptr;
		next_count = count;
		if (push && !pop) begin
			next_count = count + ONE_COUNT;
		end else if (pop && !push) begin
			next_count = count - ONE_COUNT;
		end
		next_ready = next_count != FULL_COUNT;
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			ready <= 1'b1;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			ready <= next_ready;
		end
	end

	assign in_s.ready = ready;
	assign out_s.valid = count != '0;

	ftr_mem #(.W(W), .DEPTH(DEPTH), .AW(AW)) u_mem (
		.i_mclk(i_mclk),
		.i_we(push),
		.i_waddr(wr_ptr),
		.i_wdata(in_s.data),
		.i_raddr(next_rd_ptr),
		.o_rdata(out_s.data)
	);
endmodule : ftr_fifo
`default_nettype wire

/* test/ftr_host_model.sv */
// Host-side serial master model for the register port
`default_nettype none
module ftr_host_model #(
	parameter int HALF = 8
) (
	input wire logic i_mclk,
	input wire logic i_miso,
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_mosi
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		o_sclk = 1'b1;
		o_cs_n = 1'b1;
		o_mosi = 1'b0;
	end

	// Mode 3 frame: command byte then nbits data bits, MSB first
	task automatic xfer(input logic [7:0] cmd, input logic [23:0] wdata, input int nbits,
		output logic [23:0] rdata);
		logic [31:0] sh;
		sh = {cmd, wdata << (24 - nbits)};
		rdata = '0;
		@(posedge i_mclk);
		o_cs_n <= 1'b0;
		for (int i = 0; i < 8 + nbits; i++) begin
			repeat (HALF) @(posedge i_mclk);
			o_sclk <= 1'b0;
			o_mosi <= sh[31 - i];
			repeat (HALF) @(posedge i_mclk);
			o_sclk <= 1'b1;
			if (i >= 8) rdata = {rdata[22:0], i_miso};
		end
		repeat (HALF) @(posedge i_mclk);
		o_cs_n <= 1'b1;
		// Deselected line no longer shows the last bit
		o_mosi <= ~o_mosi;
		repeat (6) @(posedge i_mclk);
	endtask : xfer
endmodule : ftr_host_model
`default_nettype wire

/* test/ftr_top_tb_top.sv */
// Self-checking bench for the FIFO threshold and readout block
`default_nettype none
module ftr_top_tb_top
	import ftr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [11:0] UP = 12'h800;
	localparam logic [11:0] LO = 12'h100;
	localparam logic [15:0] EN = 16'h0002;
	localparam logic [19:0] SMP [8] = '{20'h17FF0, 20'h11010, 20'h2FFF0, 20'h30000,
		20'h18000, 20'h11000, 20'h0ABCD, 20'h51234};

	logic i_mclk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_sample_valid = 1'b0;
	logic [DATA_W-1:0] i_sample_data = 16'h0000;
	logic [CH_W-1:0] i_sample_channel = 4'h0;
	logic [NUM_CH-1:0] i_channel_compare_enable = EN;
	logic sclk, cs_n, mosi, o_miso, o_miso_oe, miso_w, o_sample_ready;
	logic o_above_limit_flag, o_below_limit_flag, o_empty_flag;
	logic o_above_limit_irq, o_below_limit_irq, o_empty_irq;
	int failures = 0;
	int n_checks = 0;

	always #2.5 i_mclk = ~i_mclk;
	assign miso_w = o_miso_oe ? o_miso : ~o_miso;

	ftr_host_model u_host (.i_mclk(i_mclk), .i_miso(miso_w), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));

	ftr_top u_dut (
		.i_mclk(i_mclk),
		.i_resetn(i_resetn),
		.i_sclk(sclk),
		.i_cs_n(cs_n),
		.i_mosi(mosi),
		.o_miso(o_miso),
		.o_miso_oe(o_miso_oe),
		.i_sample_valid(i_sample_valid),
		.i_sample_data(i_sample_data),
		.i_sample_channel(i_sample_channel),
		.i_channel_compare_enable(i_channel_compare_enable),
		.o_sample_ready(o_sample_ready),
		.o_above_limit_flag(o_above_limit_flag),
		.o_below_limit_flag(o_below_limit_flag),
		.o_empty_flag(o_empty_flag),
		.o_above_limit_irq(o_above_limit_irq),
		.o_below_limit_irq(o_below_limit_irq),
		.o_empty_irq(o_empty_irq)
	);

	task automatic results();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic rd(input logic [5:0] a, input int n, output logic [23:0] d);
		u_host.xfer({2'b10, a}, 24'h000000, n, d);
	endtask : rd

	task automatic wr(input logic [5:0] a, input logic [23:0] v, input int n);
		logic [23:0] d;
		u_host.xfer({2'b00, a}, v, n, d);
	endtask : wr

	task automatic push(input logic [19:0] s);
		@(posedge i_mclk);
		i_sample_valid <= 1'b1;
		i_sample_data <= s[15:0];
		i_sample_channel <= s[19:16];
		@(negedge i_mclk);
		for (int t = 0; t < 100 && o_sample_ready !== 1'b1; t++) @(negedge i_mclk);
		chk(o_sample_ready, 1'b1, "sample ready wait");
		@(posedge i_mclk);
		i_sample_valid <= 1'b0;
		i_sample_data <= ~s[15:0];
	endtask : push

	task automatic flags(input logic a, input logic b, input logic e);
		repeat (3) @(negedge i_mclk);
		chk(o_above_limit_flag, a, "above flag");
		chk(o_below_limit_flag, b, "below flag");
		chk(o_empty_flag, e, "empty flag");
		chk({o_above_limit_irq, o_below_limit_irq, o_empty_irq}, {a, b, e}, "irq");
		chk(o_miso_oe, 1'b0, "miso enable idle");
	endtask : flags

	initial begin
		#200000;
		failures++;
		results();
	end

	initial begin
		logic [23:0] d;
		logic ea, eb;
		ea = 1'b0;
		eb = 1'b0;
		repeat (6) @(posedge i_mclk);
		i_resetn <= 1'b1;
		repeat (6) @(posedge i_mclk);
		flags(1'b0, 1'b0, 1'b1);
		rd(ADDR_LIMIT, 24, d);
		chk(d, LIMIT_RESET, "limit reset");
		rd(ADDR_READ, 16, d);
		chk(d, 24'h000000, "read port reset");
		// Limits changed only while the FIFO is empty
		wr(ADDR_LIMIT, {UP, LO}, 24);
		wr(ADDR_READ, 24'h00BEEF, 16);
		wr(6'h3E, 24'h00005A, 8);
		rd(ADDR_READ, 16, d);
		chk(d, 24'h000000, "read-only port");
		rd(ADDR_LIMIT, 24, d);
		chk(d, {UP, LO}, "limit readback");
		rd(6'h3E, 8, d);
		chk(d, 24'h000000, "unmapped read");
		flags(1'b0, 1'b0, 1'b1);
		for (int i = 0; i < 8; i++) begin
			push(SMP[i]);
			ea = ea | (EN[SMP[i][19:16]] && SMP[i][15:4] >= UP);
			eb = eb | (EN[SMP[i][19:16]] && SMP[i][15:4] <= LO);
			flags(ea, eb, 1'b0);
		end
		chk(o_sample_ready, 1'b0, "full");
		// Offered while full: must stay out
		@(posedge i_mclk);
		i_sample_valid <= 1'b1;
		i_sample_data <= 16'h4321;
		repeat (4) @(posedge i_mclk);
		i_sample_valid <= 1'b0;
		u_host.xfer({2'b10, ADDR_READ}, 24'h000000, 0, d);
		for (int i = 0; i < 8; i++) begin
			rd(ADDR_READ, 16, d);
			chk(d, {8'h00, SMP[i][15:0]}, "read order");
			flags(i < 7 ? ea : 1'b0, i < 7 ? eb : 1'b0, i == 7);
		end
		rd(ADDR_READ, 16, d);
		chk(d, {8'h00, SMP[7][15:0]}, "empty read");
		flags(1'b0, 1'b0, 1'b1);
		// Channel that was off now compared
		@(posedge i_mclk);
		i_channel_compare_enable <= 16'hFFFF;
		push(SMP[3]);
		flags(1'b0, 1'b1, 1'b0);
		rd(ADDR_READ, 16, d);
		chk(d, {8'h00, SMP[3][15:0]}, "enabled channel read");
		flags(1'b0, 1'b0, 1'b1);
		results();
	end
endmodule : ftr_top_tb_top
`default_nettype wire
